// ==== ahb_upsync_bridge.v ====
`timescale 1ns/1ps
`default_nettype none
`include "upsync_bridge_defs.vh"


module ahb_upsync_bridge #(
    parameter addr_width_param      = `DEF_ADDR_WIDTH,
    parameter data_width_param      = `DEF_DATA_WIDTH,  // 32 or 64
    parameter master_id_width_param = `DEF_MID_WIDTH,
    parameter burst_param           = `DEF_BURST,
    parameter write_buffer_param    = `DEF_WBUF
) (
    // clock, reset and slow segment enable
    input  wire                             ref_clk,
    input  wire                             rst,
    input  wire                             slow_clock_enable,
    // slow upstream slave port
    input  wire                             hsel_s,
    input  wire [addr_width_param-1:0]      haddr_s,
    input  wire [1:0]                       htrans_s,
    input  wire [2:0]                       hsize_s,
    input  wire                             hwrite_s,
    input  wire [3:0]                       hprot_s,
    input  wire [2:0]                       hburst_s,
    input  wire [master_id_width_param-1:0] hmaster_s,
    input  wire                             hmastlock_s,
    input  wire [data_width_param-1:0]      hwdata_s,
    input  wire                             hready_s,
    output reg                              hreadyout_s,
    output reg                              hresp_s,
    output reg  [data_width_param-1:0]      hrdata_s,
    // buffering qualifiers from the surrounding system
    input  wire                             exclusive_store,
    input  wire                             buffer_inhibit,
    // fast downstream master port
    output wire [addr_width_param-1:0]      haddr_m,
    output wire [1:0]                       htrans_m,
    output wire [2:0]                       hsize_m,
    output wire                             hwrite_m,
    output wire [3:0]                       hprot_m,
    output wire [2:0]                       hburst_m,
    output wire [master_id_width_param-1:0] hmaster_m,
    output wire                             hmastlock_m,
    output wire [data_width_param-1:0]      hwdata_m,
    input  wire                             hready_m,
    input  wire                             hresp_m,
    input  wire [data_width_param-1:0]      hrdata_m,
    // buffered write error
    output reg                              buffered_write_error_pulse
);

    // ----------------------------------------------------------------
    // word layout of a captured address phase
    // ----------------------------------------------------------------
    localparam ADDR_W = addr_width_param;
    localparam MID_W  = master_id_width_param;
    localparam P_TR   = ADDR_W;                 // transfer type
    localparam P_WR   = ADDR_W + 2;             // write flag
    localparam P_SZ   = ADDR_W + 3;             // size
    localparam P_BU   = ADDR_W + 6;             // burst
    localparam P_PR   = ADDR_W + 9;             // protection
    localparam P_MI   = ADDR_W + 13;            // master id
    localparam P_LK   = ADDR_W + 13 + MID_W;    // lock
    localparam P_BF   = ADDR_W + 14 + MID_W;    // bufferable flag
    localparam HW     = ADDR_W + MID_W + 15;    // whole word

    // ----------------------------------------------------------------
    // one-hot states
    // ----------------------------------------------------------------
    localparam [4:0] S_IDLE  = 5'h01;   // no downstream transfer
    localparam [4:0] S_DATA  = 5'h02;   // unbuffered data phase
    localparam [4:0] S_WAIT  = 5'h04;   // result held for next enable
    localparam [4:0] S_ERR   = 5'h08;   // first error cycle shown
    localparam [4:0] S_BDATA = 5'h10;   // buffered write data phase

    reg  [4:0]                  state;          // controller state
    reg                         hold_valid;     // held transfer waits
    reg                         ack_pending;    // held write awaits okay
    reg                         data_latched;   // buffered data captured
    reg                         cap_err;        // captured error response
    reg  [data_width_param-1:0] cap_rdata;      // captured read data
    wire [HW-1:0]               hold_word;      // held address phase
    wire [data_width_param-1:0] wdata_q;        // buffered write data
    wire [HW-1:0]               up_word;        // live address phase
    wire [HW-1:0]               sel_word;       // word driven downstream
    wire                        up_valid;       // upstream transfer taken
    wire                        up_buf;         // live one bufferable
    wire                        issue_held;     // send held transfer
    wire                        issue_new;      // send live transfer
    wire                        issue;          // any downstream issue
    wire                        sel_buf;        // issued one bufferable
    wire                        hold_take;      // capture into hold
    wire                        latch_take;     // capture write data

    // ----------------------------------------------------------------
    // upstream decode
    // ----------------------------------------------------------------
    // a slow address phase ends on an enable cycle only
    assign up_valid = slow_clock_enable & hsel_s & htrans_s[1] & hready_s;

    // writes with prot bit set, never reads or exclusives
    // external decode may veto buffering absent buffer
    assign up_buf = (write_buffer_param != 0) & hwrite_s
                  & hprot_s[`PROT_BUF_BIT] & ~exclusive_store & ~buffer_inhibit;

    assign up_word = {up_buf, hmastlock_s, hmaster_s, hprot_s, hburst_s,
                      hsize_s, hwrite_s, htrans_s, haddr_s};

    // held transfer goes first once downstream is free
    assign issue_held = state[0] & hold_valid;
    assign issue_new  = state[0] & ~hold_valid & up_valid;
    assign issue      = issue_held | issue_new;
    assign sel_word   = issue_held ? hold_word : up_word;
    assign sel_buf    = sel_word[P_BF];

    // a new transfer during a buffered write is parked
    assign hold_take  = state[4] & up_valid & hreadyout_s & ~hold_valid;

    // write data is valid through the enable the master sees ready on
    assign latch_take = state[4] & slow_clock_enable & hreadyout_s & ~data_latched;

    // ----------------------------------------------------------------
    // downstream forward path, combinational
    // ----------------------------------------------------------------
    assign haddr_m     = sel_word[ADDR_W-1:0];
    assign hsize_m     = sel_word[P_SZ+2:P_SZ];
    assign hwrite_m    = sel_word[P_WR];
    assign hprot_m     = sel_word[P_PR+3:P_PR];
    assign hmaster_m   = sel_word[P_MI+MID_W-1:P_MI];
    assign hmastlock_m = sel_word[P_LK];

    // bursts split into nonseq singles or passed on
    assign htrans_m = !issue ? `TRANS_IDLE :
                      (burst_param != 0) ? sel_word[P_TR+1:P_TR] : `TRANS_NONSEQ;
    assign hburst_m = (burst_param != 0) ? sel_word[P_BU+2:P_BU] : `BURST_SINGLE;

    // buffered data once latched, else the master's live data
    assign hwdata_m = (state[4] & data_latched) ? wdata_q : hwdata_s;

    // ----------------------------------------------------------------
    // holding stores
    // ----------------------------------------------------------------
    xfer_hold_reg #(
        .WIDTH   (HW)
    ) u_hold_addr (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wr_en   (hold_take),
        .wr_data (up_word),
        .rd_data (hold_word)
    );

    xfer_hold_reg #(
        .WIDTH   (data_width_param)
    ) u_hold_data (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wr_en   (latch_take),
        .wr_data (hwdata_s),
        .rd_data (wdata_q)
    );

    // ----------------------------------------------------------------
    // controller and registered feedback
    // ----------------------------------------------------------------
    // upstream ready and response only move on enable cycles
    always @(posedge ref_clk) begin
        if (rst) begin
            state                      <= S_IDLE;
            hold_valid                 <= 1'b0;
            ack_pending                <= 1'b0;
            data_latched               <= 1'b0;
            cap_err                    <= 1'b0;
            cap_rdata                  <= {data_width_param{1'b0}};
            hreadyout_s                <= 1'b1;
            hresp_s                    <= `RESP_OKAY;
            hrdata_s                   <= {data_width_param{1'b0}};
            buffered_write_error_pulse <= 1'b0;
        end else begin
            buffered_write_error_pulse <= 1'b0;
            // data capture flag
            if (latch_take) begin
                data_latched <= 1'b1;
            end
            // early okay for a held bufferable write
            if (ack_pending & slow_clock_enable) begin
                hreadyout_s <= 1'b1;
                hresp_s     <= `RESP_OKAY;
                ack_pending <= 1'b0;
            end
            // park the next transfer with wait states
            if (hold_take) begin
                hold_valid  <= 1'b1;
                hreadyout_s <= 1'b0;
                hresp_s     <= `RESP_OKAY;
            end
            case (state)
                S_IDLE: begin
                    if (issue_held) begin
                        // send the parked transfer
                        hold_valid <= 1'b0;
                        if (sel_buf) begin
                            state        <= S_BDATA;
                            data_latched <= 1'b0;
                            ack_pending  <= 1'b1;
                        end else begin
                            state <= S_DATA;       // master stays waited
                        end
                    end else if (issue_new) begin
                        hresp_s <= `RESP_OKAY;
                        if (sel_buf) begin
                            // okay at once, write done later
                            state        <= S_BDATA;
                            data_latched <= 1'b0;
                            hreadyout_s  <= 1'b1;
                        end else begin
                            // wait states until downstream ends
                            state       <= S_DATA;
                            hreadyout_s <= 1'b0;
                        end
                    end else if (slow_clock_enable) begin
                        hresp_s <= `RESP_OKAY;
                    end
                end
                S_DATA: begin
                    // answer through one register on an enable, else park
                    if (hready_m & slow_clock_enable) begin
                        hrdata_s    <= hrdata_m;
                        hresp_s     <= hresp_m;
                        hreadyout_s <= ~hresp_m;
                        state       <= hresp_m ? S_ERR : S_IDLE;
                    end else if (hready_m) begin
                        cap_err   <= hresp_m;
                        cap_rdata <= hrdata_m;
                        state     <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    // answer parked off an enable goes up on the next one
                    if (slow_clock_enable) begin
                        hrdata_s <= cap_rdata;
                        if (cap_err) begin
                            hresp_s     <= `RESP_ERROR;
                            hreadyout_s <= 1'b0;
                            state       <= S_ERR;
                        end else begin
                            hresp_s     <= `RESP_OKAY;
                            hreadyout_s <= 1'b1;
                            state       <= S_IDLE;
                        end
                    end
                end
                S_ERR: begin
                    // second cycle of the two-cycle error answer
                    if (slow_clock_enable) begin
                        hreadyout_s <= 1'b1;
                        state       <= S_IDLE;
                    end
                end
                S_BDATA: begin
                    // buffered write ends; failure flagged for one cycle
                    if (hready_m) begin
                        buffered_write_error_pulse <= hresp_m;
                        state                      <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule // ahb_upsync_bridge

`default_nettype wire

// ==== upsync_bridge_defs.vh ====
`ifndef UPSYNC_BRIDGE_DEFS_VH
`define UPSYNC_BRIDGE_DEFS_VH

// ----------------------------------------------------------------
// ahb encodings used by the bridge
// ----------------------------------------------------------------
`define TRANS_IDLE      2'h0
`define TRANS_NONSEQ    2'h2
`define BURST_SINGLE    3'h0
`define RESP_OKAY       1'h0
`define RESP_ERROR      1'h1

// protection bit that marks a write as bufferable
`define PROT_BUF_BIT    2

// ----------------------------------------------------------------
// default configuration
// ----------------------------------------------------------------
`define DEF_ADDR_WIDTH  32
`define DEF_DATA_WIDTH  32
`define DEF_MID_WIDTH   1
`define DEF_BURST       0
`define DEF_WBUF        0

`endif

// ==== xfer_hold_reg.v ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// one-entry holding store, read data straight from a register
// ----------------------------------------------------------------
module xfer_hold_reg #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire             ref_clk,
    input  wire             rst,
    // write side
    input  wire             wr_en,
    input  wire [WIDTH-1:0] wr_data,
    // read side
    output reg  [WIDTH-1:0] rd_data
);

    // capture on write enable, clear on reset
    always @(posedge ref_clk) begin
        if (rst) begin
            rd_data <= {WIDTH{1'b0}};
        end else if (wr_en) begin
            rd_data <= wr_data;
        end
    end

endmodule // xfer_hold_reg

`default_nettype wire

// ==== upsync_bridge_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "upsync_bridge_defs.vh"

module upsync_bridge_chk #(
    parameter addr_width_param      = 32,
    parameter master_id_width_param = 1
) (
    // clock, reset, enable
    input wire logic                        ref_clk, rst, slow_clock_enable,
    // slow side
    input wire logic                        hsel_s, hready_s, hwrite_s,
    input wire logic [1:0]                  htrans_s,
    input wire logic [3:0]                  hprot_s,
    input wire logic [addr_width_param-1:0] haddr_s,
    input wire logic                        exclusive_store, buffer_inhibit,
    input wire logic                        hreadyout_s, hresp_s,
    // fast side
    input wire logic [addr_width_param-1:0] haddr_m,
    input wire logic [1:0]                  htrans_m,
    input wire logic [2:0]                  hburst_m,
    input wire logic                        hwrite_m, hready_m, hresp_m,
    // forwarded control, both sides
    input wire logic [2:0]                  hsize_s, hsize_m,
    input wire logic [3:0]                  hprot_m,
    input wire logic [master_id_width_param-1:0] hmaster_s, hmaster_m,
    input wire logic                        hmastlock_s, hmastlock_m,
    input wire logic                        buffered_write_error_pulse
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic acc;     // slow address phase taken
    logic bufw;    // phase may be buffered
    logic dphase;  // downstream data phase open
    logic held;    // address taken while downstream busy
    assign acc = slow_clock_enable & hsel_s & htrans_s[1] & hready_s & hreadyout_s;
    assign bufw = hwrite_s & hprot_s[`PROT_BUF_BIT] & ~exclusive_store & ~buffer_inhibit;
    // tracks the downstream data phase, issue assumed taken at once
    always @(posedge ref_clk) begin
        if (rst) dphase <= 1'b0;
        else if (htrans_m[1]) dphase <= 1'b1;
        else if (hready_m) dphase <= 1'b0;
    end
    // a parked transfer is pending until it goes downstream
    always @(posedge ref_clk) begin
        if (rst) held <= 1'b0;
        else if (acc && dphase) held <= 1'b1;
        else if (htrans_m[1]) held <= 1'b0;
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_stand_en: assert property (
        !slow_clock_enable |=> $stable(hreadyout_s) && $stable(hresp_s))
        else $error("upstream answer changed off enable");
    a_nobuf_wait: assert property (
        acc && !bufw |=> !hreadyout_s) else $error("unbuffered phase not waited");
    a_fwd_comb: assert property (
        htrans_m[1] && hreadyout_s |-> haddr_m == haddr_s && hwrite_m == hwrite_s
            && hprot_m == hprot_s && hsize_m == hsize_s && hmaster_m == hmaster_s
            && hmastlock_m == hmastlock_s)
        else $error("address not passed through");
    a_single_beat: assert property (
        htrans_m != `TRANS_IDLE |-> htrans_m == `TRANS_NONSEQ && hburst_m == `BURST_SINGLE)
        else $error("beat not single nonseq");
    a_one_out: assert property (
        htrans_m[1] |=> !htrans_m[1]) else $error("downstream pipelined");
    a_pulse_one: assert property (
        buffered_write_error_pulse |=> !buffered_write_error_pulse)
        else $error("error pulse too long");
    a_pulse_cause: assert property (
        $rose(buffered_write_error_pulse) |-> $past(hresp_m) && $past(hready_m))
        else $error("error pulse without error");
    a_reg_answer: assert property (
        dphase && hready_m && !hreadyout_s && slow_clock_enable && !held
            |=> hreadyout_s || hresp_s)
        else $error("answer not one cycle late");
    a_answer_due: assert property (
        dphase && hready_m && !hreadyout_s |-> ##[1:40] hreadyout_s)
        else $error("upstream answer missing");
endmodule // upsync_bridge_chk

bind ahb_upsync_bridge upsync_bridge_chk #(.addr_width_param(addr_width_param),
    .master_id_width_param(master_id_width_param)) chk (
    .hsize_s(hsize_s), .hsize_m(hsize_m), .hprot_m(hprot_m), .hmaster_s(hmaster_s),
    .hmaster_m(hmaster_m), .hmastlock_s(hmastlock_s), .hmastlock_m(hmastlock_m),
    .ref_clk(ref_clk), .rst(rst), .slow_clock_enable(slow_clock_enable),
    .hsel_s(hsel_s), .hready_s(hready_s), .hwrite_s(hwrite_s), .htrans_s(htrans_s),
    .hprot_s(hprot_s), .haddr_s(haddr_s), .exclusive_store(exclusive_store),
    .buffer_inhibit(buffer_inhibit), .hreadyout_s(hreadyout_s), .hresp_s(hresp_s),
    .haddr_m(haddr_m), .htrans_m(htrans_m), .hburst_m(hburst_m), .hwrite_m(hwrite_m),
    .hready_m(hready_m), .hresp_m(hresp_m),
    .buffered_write_error_pulse(buffered_write_error_pulse));
`default_nettype wire

// ==== downstream_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// fast side slave: set wait count, optional error, two-cycle unless waits is zero
module downstream_slave_model (
    // clock and reset
    input wire logic        ref_clk, rst,
    // fast bus
    input wire logic [1:0]  htrans_m,
    input wire logic        hwrite_m,
    input wire logic [31:0] haddr_m, hwdata_m,
    output logic            hready_m, hresp_m,
    output logic [31:0]     hrdata_m,
    // behaviour and record
    input wire logic [3:0]  waits,
    input wire logic        err,
    output logic [31:0]     wr_addr, wr_data,
    output logic [7:0]      wr_count
);
    logic        busy;  // data phase open
    logic [3:0]  cnt;   // wait cycles left
    logic [31:0] a;     // phase address
    logic        w, e;  // phase write, phase error
    // read data is ~address; undriven data toggles each cycle
    always @(posedge ref_clk) begin
        if (rst) begin
            busy <= 1'b0; hready_m <= 1'b1; hresp_m <= 1'b0;
            hrdata_m <= 32'h0000_0000; wr_count <= 8'h00;
        end else if (!busy) begin
            hrdata_m <= ~hrdata_m;
            if (htrans_m[1]) begin
                busy <= 1'b1; a <= haddr_m; w <= hwrite_m; e <= err; cnt <= waits;
                hready_m <= (waits == 0);
                hresp_m <= err && (waits <= 1);
                if (waits == 0) hrdata_m <= ~haddr_m;
            end
        end else if (hready_m) begin
            // phase ends here; record the write
            busy <= 1'b0; hresp_m <= 1'b0;
            if (w) begin
                wr_addr <= a; wr_data <= hwdata_m; wr_count <= wr_count + 1;
            end
        end else begin
            cnt <= cnt - 1;
            hready_m <= (cnt == 1);
            hresp_m <= e && (cnt <= 2);
            hrdata_m <= (cnt == 1) ? ~a : ~hrdata_m;
        end
    end
endmodule // downstream_slave_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // ----------------------------------------
    // stimulus and wires
    // ----------------------------------------
    logic ref_clk = 0, rst = 1, en = 0, hsel_s = 0, hwrite_s = 0, err = 0;
    logic exclusive_store = 0, buffer_inhibit = 0;
    logic [31:0] haddr_s = 0, hwdata_s = 0, rd;
    logic [1:0]  htrans_s = 0;
    logic [3:0]  hprot_s = 0, waits = 0;
    logic [2:0]  hburst_s = 0;
    logic        rsp;
    wire         hreadyout_s, hresp_s, hwrite_m, hready_m, hresp_m, pulse;
    wire [31:0]  hrdata_s, haddr_m, hwdata_m, hrdata_m, wr_addr, wr_data;
    wire [1:0]   htrans_m;
    wire [2:0]   hburst_m;
    wire [7:0]   wr_count;
    int failures = 0, num_checks = 0, cycles = 0, div = 1, dcnt = 0, pulses = 0, nw, c, i;

    ahb_upsync_bridge #(.write_buffer_param(1)) dut (
        .ref_clk(ref_clk), .rst(rst), .slow_clock_enable(en), .hsel_s(hsel_s),
        .haddr_s(haddr_s), .htrans_s(htrans_s), .hsize_s(3'h2), .hwrite_s(hwrite_s),
        .hprot_s(hprot_s), .hburst_s(hburst_s), .hmaster_s(1'b0), .hmastlock_s(1'b0),
        .hwdata_s(hwdata_s), .hready_s(hreadyout_s), .hreadyout_s(hreadyout_s),
        .hresp_s(hresp_s), .hrdata_s(hrdata_s), .exclusive_store(exclusive_store),
        .buffer_inhibit(buffer_inhibit), .haddr_m(haddr_m), .htrans_m(htrans_m),
        .hsize_m(), .hwrite_m(hwrite_m), .hprot_m(), .hburst_m(hburst_m), .hmaster_m(),
        .hmastlock_m(), .hwdata_m(hwdata_m), .hready_m(hready_m), .hresp_m(hresp_m),
        .hrdata_m(hrdata_m), .buffered_write_error_pulse(pulse));
    downstream_slave_model slave (
        .ref_clk(ref_clk), .rst(rst), .htrans_m(htrans_m), .hwrite_m(hwrite_m),
        .haddr_m(haddr_m), .hwdata_m(hwdata_m), .hready_m(hready_m), .hresp_m(hresp_m),
        .hrdata_m(hrdata_m), .waits(waits), .err(err), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_count(wr_count));

    // clock, slow enable divider, pulse count, hang guard
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        en <= (dcnt >= div - 1);
        dcnt <= (dcnt >= div - 1) ? 0 : dcnt + 1;
        pulses <= pulses + pulse;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            end_sim;
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one slow transfer: address phase held until taken, then data phase
    task xfer(input logic [31:0] a, input logic w, input logic [3:0] p,
              input logic [1:0] tr, input logic [31:0] d);
        hsel_s <= 1; haddr_s <= a; hwrite_s <= w; hprot_s <= p; htrans_s <= tr;
        do @(posedge ref_clk); while (!(en && hreadyout_s));
        hsel_s <= 0; htrans_s <= 2'h0; hwdata_s <= d; nw = 0;
        do begin
            @(posedge ref_clk);
            if (en && !hreadyout_s) nw++;
        end while (!(en && hreadyout_s));
        rd = hrdata_s; rsp = hresp_s;
    endtask
    task wait_wr(input int n);
        for (int k = 0; k < 300 && wr_count !== n[7:0]; k++) @(posedge ref_clk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_read;
        xfer(32'h0000_0100, 0, 4'h4, 2'h2, 0);
        chk(rd, 32'hffff_feff);
        chk(nw, 1);
        chk(rsp, 0);
        $display("read test done");
    endtask
    task t_nobuf; // plain, exclusive, inhibited writes all wait
        for (i = 0; i < 3; i++) begin
            c = wr_count; exclusive_store <= (i == 1); buffer_inhibit <= (i == 2);
            xfer(32'h0000_0200 + 4 * i, 1, (i == 0) ? 4'h0 : 4'h4, 2'h2, 32'h1111_0000 + i);
            chk(wr_count, c + 1);
            chk(wr_data, 32'h1111_0000 + i);
        end
        exclusive_store <= 0; buffer_inhibit <= 0;
        $display("unbuffered test done");
    endtask
    task t_buf; // slow enable, slow slave, second write held
        div = 3; waits <= 6; c = wr_count;
        xfer(32'h0000_0300, 1, 4'h4, 2'h2, 32'h2222_aaaa);
        chk(nw, 0);
        chk(wr_count, c);
        xfer(32'h0000_0304, 1, 4'h4, 2'h2, 32'h3333_bbbb);
        chk(nw > 0, 1);
        chk(rsp, 0);
        chk(wr_count, c + 1);
        wait_wr(c + 2);
        chk(wr_addr, 32'h0000_0304);
        chk(wr_data, 32'h3333_bbbb);
        $display("buffer test done");
    endtask
    task t_err; // buffered write error pulse, then unbuffered error
        div = 1; waits <= 1; err <= 1; c = wr_count; i = pulses;
        xfer(32'h0000_0400, 1, 4'h4, 2'h2, 32'h4444_0000);
        chk(rsp, 0);
        wait_wr(c + 1);
        repeat (4) @(posedge ref_clk);
        chk(pulses - i, 1);
        xfer(32'h0000_0404, 0, 4'h0, 2'h2, 0);
        chk(rsp, 1);
        err <= 0; waits <= 0;
        $display("error test done");
    endtask
    task t_burst; // incrementing burst split into singles
        div = 2; hburst_s <= 3'h3;
        xfer(32'h0000_0500, 0, 4'h0, 2'h2, 0);
        chk(rd, 32'hffff_faff);
        xfer(32'h0000_0504, 0, 4'h0, 2'h3, 0);
        chk(rd, 32'hffff_fafb);
        hburst_s <= 0;
        $display("burst test done");
    endtask

    task end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 0;
        @(posedge ref_clk);
        t_read;
        t_nobuf;
        t_buf;
        t_err;
        t_burst;
        end_sim;
    end
endmodule // testbench
`default_nettype wire
